// file: rtl/mecc_defs.vh
`ifndef MECC_DEFS_VH
`define MECC_DEFS_VH
// register byte offsets
`define MECC_CTRL 8'h00
`define MECC_FAILDEV 8'h04
`define MECC_PATINT 8'h08
`define MECC_DECAY 8'h0C
`define MECC_STATUS 8'h10
`define MECC_PATADDR 8'h14
// control fields
`define MECC_C_DSCRUB 0
`define MECC_C_PATROL 1
`define MECC_C_LOCK 2
`define MECC_C_DEVCOR 3
`define MECC_C_X8 4
`define MECC_C_THR 10:8
`define MECC_CTRL_RST 11'h401
// status fields; a one written to AMBER clears amber and ue, to LEDCLR the leds
`define MECC_S_AMBER 0
`define MECC_S_UE 1
`define MECC_S_BUSY 2
`define MECC_S_LEDCLR 3
`define MECC_S_LED 8
// threshold selections and counts
`define MECC_THR_NONE 3'h0
`define MECC_THR_ALL 3'h1
`define MECC_THR_5 3'h2
`define MECC_THR_10 3'h3
`define MECC_THR_20 3'h4
`define MECC_CNT_ALL 5'h01
`define MECC_CNT_5 5'h05
`define MECC_CNT_10 5'h0A
`define MECC_CNT_20 5'h14
// log record kinds
`define MECC_LOG_CE 2'h1
`define MECC_LOG_UE 2'h2
// interval defaults in clock cycles
`define MECC_PATROL_RST 32'h0000_1000
`define MECC_DECAY_RST 32'h0100_0000
`endif

// file: rtl/mecc_top.v
// Contract
// - each 64-bit word is stored as 72 bits with an 8-bit hamming code made on write.
// - every read is checked, single-bit errors are corrected, single and double-bit errors reported.
// - correctable errors are counted, reported once at the threshold, and ignored until the slot led is cleared.
// - the correctable counts leak away steadily as running time passes.
// - the threshold is selectable as 20, 10, 5, every error, or never.
// - reaching the threshold emits a log record and lights that slot's fault led.
// - a detected multi-bit error that cannot be corrected is classed uncorrectable.
// - an uncorrectable error is logged, lights the slot led and solid amber before the machine check.
// - with demand scrubbing on, a corrected read is written back to the same location.
// - demand scrubbing has an enable that comes out of reset enabled.
// - data of one whole failing x4 device is rebuilt from device parity and the other devices by hardware.
// - whole-device rebuild also covers x8 devices, but only in lockstep mode.
// - a background patrol scrubber fixes correctable errors before they grow.
// - correctable counts are kept and compared per rank on each channel.
// - in lockstep each access is 128 bits across both channels at one address.
`timescale 1ns/1ps
`include "mecc_defs.vh"
module mecc_top #(
    parameter AW = 32,
    parameter RBITS = 2,
    parameter [31:0] PATROL_DEF = `MECC_PATROL_RST,
    parameter [31:0] DECAY_DEF = `MECC_DECAY_RST
) (
    input wire clk,
    input wire arst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire host_valid,
    input wire host_we,
    input wire [AW-1:0] host_addr,
    input wire [127:0] host_wdata,
    output reg host_accept,
    output reg host_rvalid,
    output reg [127:0] host_rdata,
    output reg host_rerr,
    output reg mem_valid,
    output reg mem_we,
    output reg [1:0] mem_lane,
    output reg [AW-1:0] mem_addr,
    output reg [143:0] mem_wdata,
    output reg [7:0] mem_wpar,
    input wire mem_ready,
    input wire mem_rvalid,
    input wire [143:0] mem_rdata,
    input wire [7:0] mem_rpar,
    output reg [2*(1<<RBITS)-1:0] slot_fault_led,
    output reg status_amber,
    output reg log_valid,
    output reg [1:0] log_kind,
    output reg [RBITS:0] log_slot,
    output reg machine_check_signal
);
localparam NR = 1 << RBITS;
localparam NCNT = 2 * NR;
localparam [2:0] S_IDLE = 3'b001;
localparam [2:0] S_CMD = 3'b010;
localparam [2:0] S_RESP = 3'b100;

// hamming code: data at non power-of-two positions 1..71, bit 7 overall
function [7:0] ecc_gen;
    input [63:0] d;
    integer p, j, k;
    reg [7:0] c;
    begin
        c = 8'h00;
        j = 0;
        for (p = 1; p < 72; p = p + 1) begin
            if ((p & (p - 1)) != 0) begin
                for (k = 0; k < 7; k = k + 1) begin
                    if (p[k]) c[k] = c[k] ^ d[j];
                end
                j = j + 1;
            end
        end
        c[7] = ^{d, c[6:0]};
        ecc_gen = c;
    end
endfunction

// returns {ue, ce, corrected data}
function [65:0] ecc_chk;
    input [71:0] w;
    integer p, j;
    reg [7:0] c;
    reg [6:0] s;
    reg ov;
    reg [63:0] d;
    begin
        d = w[63:0];
        c = ecc_gen(d);
        s = c[6:0] ^ w[70:64];
        ov = ^w;
        ecc_chk = {2'b00, d};
        if (ov && s > 7'h47) begin
            ecc_chk[65] = 1'b1; // bad syndrome
        end else if (ov) begin
            j = 0;
            for (p = 1; p < 72; p = p + 1) begin
                if ((p & (p - 1)) != 0) begin
                    if (p == s) d[j] = ~d[j]; // single flip
                    j = j + 1;
                end
            end
            ecc_chk = {2'b01, d};
        end else if (s != 7'h00) begin
            ecc_chk[65] = 1'b1; // double error, not fixable
        end
    end
endfunction

// device parity: x8 is one byte over 128 bits, x4 a nibble per lane
function [7:0] par_gen;
    input [127:0] d;
    input x8;
    integer k;
    reg [7:0] b;
    begin
        b = 8'h00;
        for (k = 0; k < 16; k = k + 1) begin
            if (x8) b = b ^ d[8*k +: 8];
            else b = b ^ {d[64+4*k +: 4], d[4*k +: 4]};
        end
        par_gen = b;
    end
endfunction

// rebuild the failing device's bits from parity and the others
function [127:0] dev_fix;
    input [127:0] d;
    input [7:0] pr;
    input [4:0] ix;
    input x8;
    integer k, ln;
    reg [7:0] b;
    reg [3:0] n;
    begin
        ln = ix[4];
        b = pr;
        n = pr[4*ln +: 4];
        for (k = 0; k < 16; k = k + 1) begin
            if (k != ix[3:0]) begin
                b = b ^ d[8*k +: 8];
                n = n ^ d[64*ln+4*k +: 4];
            end
        end
        dev_fix = d;
        if (x8) dev_fix[8*ix[3:0] +: 8] = b;
        else dev_fix[64*ln+4*ix[3:0] +: 4] = n;
    end
endfunction

// threshold selection to count, zero means never report
function [4:0] thr_cnt;
    input [2:0] sel;
    begin
        case (sel)
            `MECC_THR_ALL: thr_cnt = `MECC_CNT_ALL;
            `MECC_THR_5: thr_cnt = `MECC_CNT_5;
            `MECC_THR_10: thr_cnt = `MECC_CNT_10;
            `MECC_THR_20: thr_cnt = `MECC_CNT_20;
            default: thr_cnt = 5'h00;
        endcase
    end
endfunction

function [RBITS:0] low_idx;
    input [NCNT-1:0] v;
    integer k;
    begin
        low_idx = {(RBITS+1){1'b0}};
        for (k = NCNT - 1; k >= 0; k = k - 1) begin
            if (v[k]) low_idx = k[RBITS:0];
        end
    end
endfunction

function [31:0] wmerge;
    input [31:0] o;
    input [31:0] n;
    input [3:0] sel;
    integer k;
    begin
        for (k = 0; k < 4; k = k + 1) begin
            wmerge[8*k +: 8] = sel[k] ? n[8*k +: 8] : o[8*k +: 8];
        end
    end
endfunction

reg [1:0] rst_q;
wire rstn = rst_q[1];
reg [10:0] ctrl_q;
reg [4:0] fail_q;
reg [31:0] patint_q, decay_q, pat_cnt_q, dec_cnt_q;
reg [AW-1:0] pat_addr_q;
reg pat_due_q, ue_flag_q, ue_evt_q;
reg [2:0] state_q;
reg op_we_q, op_pat_q;
reg [AW-1:0] op_addr_q;
reg [1:0] op_lane_q;
reg [31:0] rd_mux;
reg [4:0] cnt_q [0:NCNT-1];
reg [NCNT-1:0] cross_q;

// reset release through two flops
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) rst_q <= 2'b00;
    else rst_q <= {rst_q[0], 1'b1};
end

wire lock = ctrl_q[`MECC_C_LOCK];
wire x8on = ctrl_q[`MECC_C_X8] & lock; // x8 rebuild needs lockstep
wire dev_on = ctrl_q[`MECC_C_DEVCOR] & (~ctrl_q[`MECC_C_X8] | lock);
wire [4:0] thr = thr_cnt(ctrl_q[`MECC_C_THR]);
wire wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_go & wb_we_i;
wire st_wr = wb_wr && wb_adr_i == `MECC_STATUS;
wire clr_ue = st_wr & wb_sel_i[0] & wb_dat_i[`MECC_S_AMBER];
wire clr_led = st_wr & wb_sel_i[0] & wb_dat_i[`MECC_S_LEDCLR];
wire resp = state_q[2] & mem_rvalid;
// compare with >= so a shortened period takes effect without a wrap-around
wire dec_tick = dec_cnt_q >= decay_q;
wire [31:0] ctrl_wm = wmerge({21'h00_0000, ctrl_q}, wb_dat_i, wb_sel_i);

// read path: device rebuild first, then per-lane hamming check
wire [127:0] raw = {mem_rdata[135:72], mem_rdata[63:0]};
wire [127:0] rb = dev_on ? dev_fix(raw, mem_rpar, fail_q, x8on) : raw;
wire [65:0] chk0 = ecc_chk({mem_rdata[71:64], rb[63:0]});
wire [65:0] chk1 = ecc_chk({mem_rdata[143:136], rb[127:64]});
wire [127:0] fixd = {chk1[63:0], chk0[63:0]};
wire [1:0] ce_l = {chk1[64], chk0[64]} & op_lane_q;
wire [1:0] ue_l = {chk1[65], chk0[65]} & op_lane_q;
wire ue_any = resp & (|ue_l);
wire ce_any = resp & (|ce_l);
wire [RBITS-1:0] op_rank = op_addr_q[AW-1 -: RBITS];
wire scrub = ce_any & ~(|ue_l)
    & (op_pat_q | ctrl_q[`MECC_C_DSCRUB]);
// write source: corrected words on write-back, host data otherwise
wire [127:0] wsrc = state_q[2] ? fixd
    : (lock ? host_wdata : {2{host_wdata[63:0]}});
wire [143:0] wenc = {ecc_gen(wsrc[127:64]), wsrc[127:64],
    ecc_gen(wsrc[63:0]), wsrc[63:0]};
wire [1:0] hlane = lock ? 2'b11 : (host_addr[0] ? 2'b10 : 2'b01);
wire [1:0] plane = lock ? 2'b11 : (pat_addr_q[0] ? 2'b10 : 2'b01);
wire [NCNT-1:0] hit_w;
wire [NCNT-1:0] uled_w;

// one counter per rank and channel
genvar g;
generate
    for (g = 0; g < NCNT; g = g + 1) begin : g_cnt
        wire here = op_rank == (g % NR);
        wire inc = ce_any & ce_l[g/NR] & ~(|ue_l) & here
            & ~cross_q[g] & (thr != 5'h00);
        wire [4:0] base = clr_led ? 5'h00 : cnt_q[g];
        assign hit_w[g] = inc && (cnt_q[g] + 5'h01 >= thr);
        assign uled_w[g] = ue_any & ue_l[g/NR] & here;
        always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                cnt_q[g] <= 5'h00;
                cross_q[g] <= 1'b0;
                slot_fault_led[g] <= 1'b0;
            end else begin
                if (inc) cnt_q[g] <= base + 5'h01;
                else if (dec_tick && base != 5'h00)
                    cnt_q[g] <= base - 5'h01; // leak one
                else cnt_q[g] <= base;
                // a new hit wins over a software clear
                cross_q[g] <= hit_w[g] | (cross_q[g] & ~clr_led);
                slot_fault_led[g] <= hit_w[g] | uled_w[g]
                    | (slot_fault_led[g] & ~clr_led);
            end
        end
    end
endgenerate

// register read mux
always @* begin
    case (wb_adr_i)
        `MECC_CTRL: rd_mux = {21'h00_0000, ctrl_q};
        `MECC_FAILDEV: rd_mux = {27'h000_0000, fail_q};
        `MECC_PATINT: rd_mux = patint_q;
        `MECC_DECAY: rd_mux = decay_q;
        `MECC_STATUS: begin
            rd_mux = 32'h0000_0000;
            rd_mux[`MECC_S_AMBER] = status_amber;
            rd_mux[`MECC_S_UE] = ue_flag_q;
            rd_mux[`MECC_S_BUSY] = ~state_q[0];
            rd_mux[`MECC_S_LED +: NCNT] = slot_fault_led;
        end
        `MECC_PATADDR: rd_mux = pat_addr_q[31:0];
        default: rd_mux = 32'h0000_0000;
    endcase
end

// wishbone slave, one wait state, unmapped reads give zero
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
        ctrl_q <= `MECC_CTRL_RST; // demand scrub on at reset
        fail_q <= 5'h00;
        patint_q <= PATROL_DEF;
        decay_q <= DECAY_DEF;
    end else begin
        wb_ack_o <= wb_go;
        wb_dat_o <= wb_go ? rd_mux : 32'h0000_0000;
        if (wb_wr) begin
            case (wb_adr_i)
                `MECC_CTRL: ctrl_q <= ctrl_wm[10:0] & 11'h71F;
                `MECC_FAILDEV: fail_q <= wb_sel_i[0] ? wb_dat_i[4:0] : fail_q;
                `MECC_PATINT: patint_q <= wmerge(patint_q, wb_dat_i, wb_sel_i);
                `MECC_DECAY: decay_q <= wmerge(decay_q, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end
end

// patrol interval and decay period timers
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        pat_cnt_q <= 32'h0000_0000;
        dec_cnt_q <= 32'h0000_0000;
        pat_due_q <= 1'b0;
    end else begin
        dec_cnt_q <= dec_tick ? 32'h0000_0000 : dec_cnt_q + 32'h0000_0001;
        if (!ctrl_q[`MECC_C_PATROL]) begin
            pat_cnt_q <= 32'h0000_0000;
            pat_due_q <= 1'b0;
        end else if (state_q[0] && pat_due_q && !host_valid) begin
            pat_due_q <= 1'b0; // consumed by the patrol read
        end else if (pat_cnt_q >= patint_q) begin
            pat_cnt_q <= 32'h0000_0000;
            pat_due_q <= 1'b1;
        end else begin
            pat_cnt_q <= pat_cnt_q + 32'h0000_0001;
        end
    end
end

// access sequencer: host first, patrol fills idle gaps
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        state_q <= S_IDLE;
        op_we_q <= 1'b0;
        op_pat_q <= 1'b0;
        op_addr_q <= {AW{1'b0}};
        op_lane_q <= 2'b00;
        pat_addr_q <= {AW{1'b0}};
        host_accept <= 1'b0;
        host_rvalid <= 1'b0;
        host_rdata <= 128'h0;
        host_rerr <= 1'b0;
        mem_valid <= 1'b0;
        mem_we <= 1'b0;
        mem_lane <= 2'b00;
        mem_addr <= {AW{1'b0}};
        mem_wdata <= 144'h0;
        mem_wpar <= 8'h00;
    end else begin
        host_accept <= 1'b0;
        host_rvalid <= 1'b0;
        host_rerr <= 1'b0;
        case (state_q)
            S_IDLE: begin
                if (host_valid && !host_accept) begin
                    host_accept <= 1'b1;
                    op_we_q <= host_we;
                    op_pat_q <= 1'b0;
                    op_addr_q <= host_addr;
                    op_lane_q <= hlane;
                    mem_valid <= 1'b1;
                    mem_we <= host_we;
                    mem_lane <= hlane; // hlane: both lanes in lockstep, else one lane by host_addr[0]
                    mem_addr <= host_addr;
                    mem_wdata <= wenc;
                    mem_wpar <= par_gen(wsrc, x8on);
                    state_q <= S_CMD;
                end else if (pat_due_q && !host_valid) begin
                    op_we_q <= 1'b0;
                    op_pat_q <= 1'b1;
                    op_addr_q <= pat_addr_q;
                    op_lane_q <= plane;
                    mem_valid <= 1'b1;
                    mem_we <= 1'b0;
                    mem_lane <= plane;
                    mem_addr <= pat_addr_q;
                    pat_addr_q <= pat_addr_q + {{(AW-1){1'b0}}, 1'b1};
                    state_q <= S_CMD;
                end
            end
            S_CMD: begin
                if (mem_ready) begin
                    mem_valid <= 1'b0;
                    state_q <= op_we_q ? S_IDLE : S_RESP;
                end
            end
            S_RESP: begin
                if (mem_rvalid) begin
                    if (!op_pat_q) begin
                        host_rvalid <= 1'b1;
                        host_rerr <= |ue_l;
                        host_rdata <= lock ? fixd : {64'h0000_0000_0000_0000,
                            op_lane_q[1] ? fixd[127:64] : fixd[63:0]};
                    end
                    if (scrub) begin
                        op_we_q <= 1'b1;
                        mem_valid <= 1'b1;
                        mem_we <= 1'b1; // corrected word, same place
                        mem_wdata <= wenc;
                        mem_wpar <= par_gen(wsrc, x8on);
                        state_q <= S_CMD;
                    end else begin
                        state_q <= S_IDLE;
                    end
                end
            end
            default: state_q <= S_IDLE;
        endcase
    end
end

// event reporting: log, led and amber first, machine check a cycle later
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        log_valid <= 1'b0;
        log_kind <= 2'h0;
        log_slot <= {(RBITS+1){1'b0}};
        status_amber <= 1'b0;
        ue_flag_q <= 1'b0;
        ue_evt_q <= 1'b0;
        machine_check_signal <= 1'b0;
    end else begin
        log_valid <= ue_any | (|hit_w);
        if (ue_any) begin
            log_kind <= `MECC_LOG_UE;
            log_slot <= low_idx(uled_w);
        end else if (|hit_w) begin
            log_kind <= `MECC_LOG_CE;
            log_slot <= low_idx(hit_w);
        end
        status_amber <= ue_any | (status_amber & ~clr_ue);
        ue_flag_q <= ue_any | (ue_flag_q & ~clr_ue);
        ue_evt_q <= ue_any;
        machine_check_signal <= ue_evt_q; // after log and leds
    end
end

endmodule // mecc_top

// file: sim/mecc_monitor.sv
`timescale 1ns/1ps
`include "mecc_defs.vh"
module mecc_monitor #(
    parameter AW = 32,
    parameter RBITS = 2
) (
    input wire clk,
    input wire arst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire host_accept,
    input wire host_rvalid,
    input wire host_rerr,
    input wire mem_valid,
    input wire mem_we,
    input wire [AW-1:0] mem_addr,
    input wire mem_ready,
    input wire mem_rvalid,
    input wire [2*(1<<RBITS)-1:0] slot_fault_led,
    input wire status_amber,
    input wire log_valid,
    input wire [1:0] log_kind,
    input wire [RBITS:0] log_slot,
    input wire machine_check_signal
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // a fatal read reports first, the machine check follows one cycle later
    sequence s_ue_hit;
        host_rvalid && host_rerr;
    endsequence
    sequence s_ue_report;
        status_amber && log_valid && log_kind == `MECC_LOG_UE
            ##1 machine_check_signal;
    endsequence
    AST_WB_ACK: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("register request not acknowledged");
    AST_WB_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    AST_MEM_HOLD: assert property (mem_valid && !mem_ready |=>
        mem_valid && $stable(mem_addr) && $stable(mem_we))
        else $error("memory command changed before ready");
    AST_ACCEPT_PULSE: assert property (host_accept |=> !host_accept)
        else $error("accept longer than one cycle");
    AST_RD_CAUSE: assert property (host_rvalid |-> $past(mem_rvalid))
        else $error("host read without memory data");
    AST_UE_ORDER: assert property (s_ue_hit |-> s_ue_report)
        else $error("fatal read not reported before machine check");
    AST_MC_CAUSE: assert property (machine_check_signal |->
        $past(log_valid) && $past(log_kind) == `MECC_LOG_UE && status_amber)
        else $error("machine check without prior log and amber");
    AST_LED_CAUSE: assert property (
        (slot_fault_led & ~$past(slot_fault_led)) != '0 |-> log_valid)
        else $error("fault led lit without a log record");
    AST_AMBER_CAUSE: assert property ($rose(status_amber) |->
        log_valid && log_kind == `MECC_LOG_UE)
        else $error("amber without fatal log record");
    AST_LOG_SLOT: assert property (
        log_valid && log_kind == `MECC_LOG_CE |-> slot_fault_led[log_slot])
        else $error("threshold log without its slot led");
endmodule // mecc_monitor

bind mecc_top mecc_monitor #(.AW(AW), .RBITS(RBITS)) i_mon (.*);

// file: sim/mecc_mem_model.sv
`timescale 1ns/1ps
module mecc_mem_model (
    input wire clk,
    input wire mem_valid,
    input wire mem_we,
    input wire [1:0] mem_lane,
    input wire [31:0] mem_addr,
    input wire [143:0] mem_wdata,
    input wire [7:0] mem_wpar,
    input wire slow,
    output logic mem_ready = 1'b0,
    output logic mem_rvalid = 1'b0,
    output logic [143:0] mem_rdata = '0,
    output logic [7:0] mem_rpar = 8'h00
);
    logic [143:0] mem [0:15];
    logic [7:0] par [0:15];
    logic [3:0] cnt = 4'h0;
    logic [3:0] ra = 4'h0;
    logic pend = 1'b0;
    // all-zero words carry a valid code, so patrol never reads unknowns
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = '0;
            par[i] = 8'h00;
        end
    end
    // slow mode takes one command in four cycles; idle data lines wander
    always @(posedge clk) begin
        cnt <= cnt + 4'h1;
        mem_ready <= mem_valid && !mem_ready && (!slow || cnt[1:0] == 2'h3);
        pend <= 1'b0;
        mem_rvalid <= pend;
        mem_rdata <= pend ? mem[ra] : ~mem_rdata;
        mem_rpar <= pend ? par[ra] : ~mem_rpar;
        if (mem_valid && mem_ready && mem_we) begin
            if (mem_lane[0]) mem[mem_addr[3:0]][71:0] <= mem_wdata[71:0];
            if (mem_lane[1]) mem[mem_addr[3:0]][143:72] <= mem_wdata[143:72];
            par[mem_addr[3:0]] <= mem_wpar;
        end else if (mem_valid && mem_ready) begin
            pend <= 1'b1;
            ra <= mem_addr[3:0];
        end
    end
endmodule // mecc_mem_model

// file: sim/mecc_top_tb.sv
`timescale 1ns/1ps
`include "mecc_defs.vh"
module mecc_top_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, host_addr = 32'h0000_0000;
    logic host_valid = 1'b0, host_we = 1'b0, slow = 1'b0;
    logic [127:0] host_wdata = '0, q;
    wire [31:0] wb_dat_o, mem_addr;
    wire wb_ack_o, host_accept, host_rvalid, host_rerr, mem_valid, mem_we;
    wire mem_ready, mem_rvalid, status_amber, log_valid, machine_check_signal;
    wire [127:0] host_rdata;
    wire [1:0] mem_lane, log_kind;
    wire [143:0] mem_wdata, mem_rdata;
    wire [7:0] mem_wpar, mem_rpar, slot_fault_led;
    wire [2:0] log_slot;
    integer err_count = 0, checks_done = 0, cycles = 0, ce_logs = 0;
    integer seed = 32'hb0e3_454a;
    logic [63:0] d, d3;
    logic [143:0] w;
    logic [31:0] wq[$];
    logic [128:0] hq[$];
    int pos[4] = '{0, 63, 64, 71};
    int thr[5] = '{1, 2, 3, 4, 0};
    int lim[5] = '{1, 5, 10, 20, 21};

    // every port meets the bench signal of the same name
    mecc_top #(.PATROL_DEF(32'h0000_0010), .DECAY_DEF(32'h0000_0040)) i_dut (
        .*);
    mecc_mem_model i_mem (.clk(clk), .mem_valid(mem_valid), .mem_we(mem_we),
        .mem_lane(mem_lane), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_wpar(mem_wpar), .slow(slow), .mem_ready(mem_ready),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_rpar(mem_rpar));

    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp_val(input logic [143:0] got, input logic [143:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t value got %h exp %h", $time, got, exp);
        end
    endtask

    // data of a fatal read is undefined, so only the flag is compared then
    task automatic cmp_read(input logic [128:0] got, input logic [128:0] exp);
        checks_done++;
        if (got[128] !== exp[128] || (!exp[128] && got !== exp)) begin
            err_count++;
            $display("ERROR %0t read got %h exp %h", $time, got, exp);
        end
    endtask

    // one classic cycle; for reads v is the expected word
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= v;
        wb_sel_i <= 4'hF;
        if (!we) wq.push_back(v);
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // one host request, then wait until any write-back has left
    task automatic host(input logic we, input logic [31:0] a,
                        input logic [127:0] v, input logic [128:0] exp);
        @(posedge clk);
        host_valid <= 1'b1;
        host_we <= we;
        host_addr <= a;
        host_wdata <= v;
        do @(posedge clk); while (host_accept !== 1'b1);
        host_valid <= 1'b0;
        if (!we) hq.push_back(exp);
        if (!we) do @(posedge clk); while (host_rvalid !== 1'b1);
        @(posedge clk);
        while (mem_valid !== 1'b0) @(posedge clk);
    endtask

    task automatic rd(input logic [31:0] a, input logic [63:0] v);
        host(1'b0, a, '0, {65'h0, v});
    endtask

    task automatic flip(input int i, input int b);
        i_mem.mem[i][b] = ~i_mem.mem[i][b];
    endtask

    // repeated single-bit faults on rank 2 channel 1; at = expected crossing
    task automatic ce_burst(input int cnt, input int at);
        int base;
        base = ce_logs;
        for (int j = 1; j <= cnt; j++) begin
            flip(3, 77);
            rd(32'h8000_0003, d3);
            cmp_val(144'(ce_logs - base), 144'(at > 0 && j >= at));
        end
    endtask

    // results are matched against the oldest note as they appear
    always @(posedge clk) begin
        if (wb_ack_o && !wb_we_i)
            cmp_val(144'(wb_dat_o), 144'(wq.pop_front()));
        if (host_rvalid) cmp_read({host_rerr, host_rdata}, hq.pop_front());
        if (log_valid && log_kind == `MECC_LOG_CE) ce_logs++;
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        wb(1'b0, `MECC_CTRL, 32'h0000_0401);
        wb(1'b0, 8'h18, 32'h0000_0000);
        $display("test reset done");
        d = {$random(seed), $random(seed)};
        host(1'b1, 32'h0000_0001, {64'h0, d}, '0);
        w = i_mem.mem[1];
        cmp_val(144'(w[135:72]), 144'(d));
        for (int i = 0; i < 4; i++) begin
            flip(1, 72 + pos[i]);
            rd(32'h0000_0001, d);
            cmp_val(i_mem.mem[1], w);
        end
        wb(1'b1, `MECC_CTRL, 32'h0000_0400);
        flip(1, 77);
        rd(32'h0000_0001, d);
        cmp_val(i_mem.mem[1], w ^ (144'h1 << 77));
        flip(1, 77);
        wb(1'b1, `MECC_CTRL, 32'h0000_0401);
        $display("test correction and demand scrub done");
        flip(1, 75);
        flip(1, 81);
        host(1'b0, 32'h0000_0001, '0, {1'b1, 128'h0});
        cmp_val(144'({status_amber, slot_fault_led[4]}), 144'h3);
        wb(1'b0, `MECC_STATUS, 32'h0000_1003);
        wb(1'b1, `MECC_STATUS, 32'h0000_0009);
        wb(1'b0, `MECC_STATUS, 32'h0000_0000);
        i_mem.mem[1] = w;
        $display("test uncorrectable done");
        d3 = {$random(seed), $random(seed)};
        host(1'b1, 32'h8000_0003, {64'h0, d3}, '0);
        wb(1'b1, `MECC_DECAY, 32'h0010_0000);
        for (int k = 0; k < 5; k++) begin
            wb(1'b1, `MECC_CTRL, {21'h0, thr[k][2:0], 8'h01});
            wb(1'b1, `MECC_STATUS, 32'h0000_0008);
            ce_burst(lim[k] + 1, thr[k] == 0 ? 0 : lim[k]);
            cmp_val(144'(slot_fault_led), thr[k] == 0 ? 144'h0 : 144'h40);
        end
        $display("test thresholds done");
        wb(1'b1, `MECC_CTRL, 32'h0000_0201);
        wb(1'b1, `MECC_STATUS, 32'h0000_0008);
        wb(1'b1, `MECC_DECAY, 32'h0000_0040);
        ce_burst(4, 0);
        repeat (300) @(posedge clk);
        ce_burst(4, 0);
        $display("test decay done");
        d = {$random(seed), $random(seed)};
        host(1'b1, 32'h0000_0000, {64'h0, d}, '0);
        wb(1'b1, `MECC_FAILDEV, 32'h0000_0003);
        wb(1'b1, `MECC_CTRL, 32'h0000_0409);
        for (int b = 12; b < 16; b++) flip(0, b);
        rd(32'h0000_0000, d);
        $display("test device rebuild done");
        slow <= 1'b1;
        q = {$random(seed), $random(seed), $random(seed), $random(seed)};
        wb(1'b1, `MECC_CTRL, 32'h0000_0405);
        host(1'b1, 32'h0000_0002, q, '0);
        host(1'b0, 32'h0000_0002, '0, {1'b0, q});
        w = i_mem.mem[2];
        cmp_val(144'({w[135:72], w[63:0]}), 144'(q));
        $display("test lockstep done");
        wb(1'b1, `MECC_CTRL, 32'h0000_0403);
        w = i_mem.mem[1];
        flip(1, 77);
        repeat (700) @(posedge clk);
        cmp_val(i_mem.mem[1], w);
        wb(1'b1, `MECC_CTRL, 32'h0000_0401);
        $display("test patrol done");
        tally_and_finish();
    end
endmodule // mecc_top_tb
